/* realtime_pkg.sv */
// Purpose: Shared constants for the countdown timer and calendar block.
// Assumes: 32-bit AHB-Lite register bus, one register per aligned word.
// Notes: Register offsets are byte addresses.
package realtime_pkg;
  localparam logic [7:0] OFS_DATE_COUNT = 8'h00;
  localparam logic [7:0] OFS_DATE_ALARM = 8'h04;
  localparam logic [7:0] OFS_DATE_PRESET = 8'h08;
  localparam logic [7:0] OFS_YEAR_COUNT = 8'h0C;
  localparam logic [7:0] OFS_YEAR_ALARM = 8'h10;
  localparam logic [7:0] OFS_YEAR_PRESET = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
  localparam logic [7:0] OFS_RAW_STATUS = 8'h20;
  localparam logic [7:0] OFS_MASKED_STATUS = 8'h24;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h28;
  localparam logic [7:0] OFS_COUNTDOWN = 8'h2C;
  localparam logic [7:0] OFS_TIMER_CTRL = 8'h30;
  localparam logic [7:0] OFS_FIRST_RELOAD = 8'h34;
  localparam logic [7:0] OFS_SECOND_RELOAD = 8'h38;
  localparam logic [7:0] OFS_PATTERN0 = 8'h3C;
  localparam logic [7:0] OFS_PATTERN3 = 8'h48;
  // Timer control fields.
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_ONESHOT_BIT = 1;
  localparam int CTRL_SELFSTART_BIT = 2;
  localparam int CTRL_PATLEN_LSB = 4;
  localparam int CTRL_PATLEN_MSB = 10;
  // Interrupt bit positions in mask, status and clear registers.
  localparam int IRQ_ALARM_BIT = 0;
  localparam int IRQ_COUNTDOWN_BIT = 1;
  // Date field positions.
  localparam int SEC_LSB = 0;
  localparam int MIN_LSB = 6;
  localparam int HOUR_LSB = 12;
  localparam int DAYW_LSB = 17;
  localparam int DAYM_LSB = 20;
  localparam int MONTH_LSB = 25;
  // Reset values and the last year before the year count wraps to zero.
  localparam logic [31:0] DATE_COUNT_RST = 32'h0212_0000;
  localparam logic [13:0] YEAR_COUNT_RST = 14'h2000;
  localparam logic [13:0] YEAR_ALARM_RST = 14'h2000;
  localparam logic [31:0] COUNTDOWN_RST = 32'h0FFF_FFFF;
  localparam logic [13:0] YEAR_LAST = 14'h1000;
endpackage : realtime_pkg

/* realtime_timer_calendar.sv */
// Purpose: Countdown timer with reload pattern and a calendar with alarm.
// Assumes: lsclk_i and one_hz_tick_i are asynchronous pins, sampled on clk_i.
// Notes: Zero-wait AHB-Lite slave; response is always OKAY.
//
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module realtime_timer_calendar
  import realtime_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // AHB-Lite slave.
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Time bases.
  input wire logic lsclk_i,
  input wire logic one_hz_tick_i,
  // Interrupts.
  output logic combined_irq_o
);

  logic ls_s1_r, ls_s2_r, ls_s3_r, hz_s1_r, hz_s2_r, hz_s3_r;
  logic ls_tick, hz_tick;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] ctrl_r, first_reload_value_r, second_reload_value_r, countdown_value_r;
  logic [127:0] pattern_r;
  logic [6:0] pat_idx_r;
  logic [31:0] date_time_count_r, date_time_alarm_r, date_time_preset_r;
  logic [13:0] year_count_r, year_alarm_r, year_preset_r;
  logic preset_pend_r, cal_upd_r;
  logic [1:0] irq_mask_reg_r, raw_irq_status_r;
  logic wr_ctrl, wr_rl1, wr_rl2, wr_clr, timer_run_bit, oneshot_select, zero_evt;
  logic alarm_match, pat_bit;
  logic [31:0] date_nxt;
  logic [13:0] year_nxt;

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign timer_run_bit = ctrl_r[CTRL_RUN_BIT];
  assign oneshot_select = ctrl_r[CTRL_ONESHOT_BIT];

  // Input synchronisers; the third stage only serves edge detection.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ls_s1_r <= 1'b0;
      ls_s2_r <= 1'b0;
      ls_s3_r <= 1'b0;
      hz_s1_r <= 1'b0;
      hz_s2_r <= 1'b0;
      hz_s3_r <= 1'b0;
    end else begin
      ls_s1_r <= lsclk_i;
      ls_s2_r <= ls_s1_r;
      ls_s3_r <= ls_s2_r;
      hz_s1_r <= one_hz_tick_i;
      hz_s2_r <= hz_s1_r;
      hz_s3_r <= hz_s2_r;
    end
  end
  assign ls_tick = ls_s2_r & ~ls_s3_r;
  assign hz_tick = hz_s2_r & ~hz_s3_r;

  // Bus address phase capture for writes.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else if (hready_i) begin
      wr_pend_r <= hsel_i & htrans_i[1] & hwrite_i;
      wr_addr_r <= haddr_i[7:0];
    end
  end
  assign wr_ctrl = wr_pend_r && (wr_addr_r == OFS_TIMER_CTRL);
  assign wr_rl1 = wr_pend_r && (wr_addr_r == OFS_FIRST_RELOAD);
  assign wr_rl2 = wr_pend_r && (wr_addr_r == OFS_SECOND_RELOAD);
  assign wr_clr = wr_pend_r && (wr_addr_r == OFS_IRQ_CLEAR);
  assign zero_evt = ls_tick && timer_run_bit && (countdown_value_r == 32'h0000_0000);
  assign pat_bit = pattern_r[pat_idx_r];

  // Read data is taken in the address phase and registered.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
      if (haddr_i[7:0] == OFS_DATE_COUNT) begin
        hrdata_o <= date_time_count_r;
      end else if (haddr_i[7:0] == OFS_DATE_ALARM) begin
        hrdata_o <= date_time_alarm_r;
      end else if (haddr_i[7:0] == OFS_DATE_PRESET) begin
        hrdata_o <= date_time_preset_r;
      end else if (haddr_i[7:0] == OFS_YEAR_COUNT) begin
        hrdata_o <= {18'h00000, year_count_r};
      end else if (haddr_i[7:0] == OFS_YEAR_ALARM) begin
        hrdata_o <= {18'h00000, year_alarm_r};
      end else if (haddr_i[7:0] == OFS_YEAR_PRESET) begin
        hrdata_o <= {18'h00000, year_preset_r};
      end else if (haddr_i[7:0] == OFS_IRQ_MASK) begin
        hrdata_o <= {30'h0000_0000, irq_mask_reg_r};
      end else if (haddr_i[7:0] == OFS_RAW_STATUS) begin
        hrdata_o <= {30'h0000_0000, raw_irq_status_r};
      end else if (haddr_i[7:0] == OFS_MASKED_STATUS) begin
        hrdata_o <= {30'h0000_0000, raw_irq_status_r & irq_mask_reg_r};
      end else if (haddr_i[7:0] == OFS_COUNTDOWN) begin
        hrdata_o <= countdown_value_r;
      end else if (haddr_i[7:0] == OFS_TIMER_CTRL) begin
        hrdata_o <= ctrl_r;
      end else if (haddr_i[7:0] == OFS_FIRST_RELOAD) begin
        hrdata_o <= first_reload_value_r;
      end else if (haddr_i[7:0] == OFS_SECOND_RELOAD) begin
        hrdata_o <= second_reload_value_r;
      end else if (haddr_i[7:0] >= OFS_PATTERN0 && haddr_i[7:0] <= OFS_PATTERN3) begin
        hrdata_o <= pattern_r[32*((haddr_i[7:0] - OFS_PATTERN0) >> 2) +: 32];
      end else begin
        hrdata_o <= 32'h0000_0000;
      end
    end
  end

  // Timer control: software writes win; hardware halts one-shot at zero.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r <= 32'h0000_0000;
    end else if (wr_ctrl) begin
      ctrl_r <= {21'h000000, hwdata_i[10:0]};
    end else if ((wr_rl1 || wr_rl2) && !timer_run_bit && oneshot_select
                 && ctrl_r[CTRL_SELFSTART_BIT]) begin
      ctrl_r[CTRL_RUN_BIT] <= 1'b1;
    end else if (zero_evt && oneshot_select) begin
      ctrl_r[CTRL_RUN_BIT] <= 1'b0;
    end
  end

  // Reload values and pattern.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      first_reload_value_r <= 32'h0000_0000;
      second_reload_value_r <= 32'h0000_0000;
      pattern_r <= '0;
    end else begin
      if (wr_rl1 && !timer_run_bit) begin
        first_reload_value_r <= hwdata_i;
      end
      if (wr_rl2 && !timer_run_bit) begin
        second_reload_value_r <= hwdata_i;
      end
      if (wr_pend_r && wr_addr_r >= OFS_PATTERN0 && wr_addr_r <= OFS_PATTERN3) begin
        pattern_r[32*((wr_addr_r - OFS_PATTERN0) >> 2) +: 32] <= hwdata_i;
      end
    end
  end

  // Down-counter.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      countdown_value_r <= COUNTDOWN_RST;
    end else if ((wr_rl1 || wr_rl2) && !timer_run_bit && oneshot_select) begin
      countdown_value_r <= hwdata_i;
    end else if (wr_ctrl && hwdata_i[CTRL_RUN_BIT] && !timer_run_bit) begin
      countdown_value_r <= first_reload_value_r;
    end else if (zero_evt) begin
      if (!oneshot_select) begin
        countdown_value_r <= pat_bit ? second_reload_value_r : first_reload_value_r;
      end
    end else if (ls_tick && timer_run_bit) begin
      countdown_value_r <= countdown_value_r - 32'h0000_0001;
    end
  end

  // Pattern index advances once per periodic interrupt.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pat_idx_r <= 7'h00;
    end else if (wr_ctrl && hwdata_i[CTRL_RUN_BIT] && !timer_run_bit) begin
      pat_idx_r <= 7'h00;
    end else if (zero_evt && !oneshot_select) begin
      if (pat_idx_r + 7'h01 >= ctrl_r[CTRL_PATLEN_MSB:CTRL_PATLEN_LSB]) begin
        pat_idx_r <= 7'h00;
      end else begin
        pat_idx_r <= pat_idx_r + 7'h01;
      end
    end
  end

  // Next calendar value from one second of carry.
  function automatic logic [4:0] days_in_month(input logic [3:0] mon, input logic leap);
    case (mon)
      4'h4, 4'h6, 4'h9, 4'hB: days_in_month = 5'h1E;
      4'h2: days_in_month = leap ? 5'h1D : 5'h1C;
      default: days_in_month = 5'h1F;
    endcase
  endfunction : days_in_month

  always_comb begin
    date_nxt = date_time_count_r;
    year_nxt = year_count_r;
    date_nxt[SEC_LSB +: 6] = date_time_count_r[SEC_LSB +: 6] + 6'h01;
    if (date_time_count_r[SEC_LSB +: 6] >= 6'h3B) begin
      date_nxt[SEC_LSB +: 6] = 6'h00;
      date_nxt[MIN_LSB +: 6] = date_time_count_r[MIN_LSB +: 6] + 6'h01;
      if (date_time_count_r[MIN_LSB +: 6] >= 6'h3B) begin
        date_nxt[MIN_LSB +: 6] = 6'h00;
        date_nxt[HOUR_LSB +: 5] = date_time_count_r[HOUR_LSB +: 5] + 5'h01;
        if (date_time_count_r[HOUR_LSB +: 5] >= 5'h17) begin
          date_nxt[HOUR_LSB +: 5] = 5'h00;
          date_nxt[DAYW_LSB +: 3] = (date_time_count_r[DAYW_LSB +: 3] >= 3'h7) ? 3'h1
                                    : date_time_count_r[DAYW_LSB +: 3] + 3'h1;
          date_nxt[DAYM_LSB +: 5] = date_time_count_r[DAYM_LSB +: 5] + 5'h01;
          if (date_time_count_r[DAYM_LSB +: 5] >= days_in_month(
                date_time_count_r[MONTH_LSB +: 4], year_count_r[1:0] == 2'b00)) begin
            date_nxt[DAYM_LSB +: 5] = 5'h01;
            date_nxt[MONTH_LSB +: 4] = date_time_count_r[MONTH_LSB +: 4] + 4'h1;
            if (date_time_count_r[MONTH_LSB +: 4] >= 4'hC) begin
              date_nxt[MONTH_LSB +: 4] = 4'h1;
              year_nxt = (year_count_r >= YEAR_LAST) ? 14'h0000
                         : year_count_r + 14'h0001;
            end
          end
        end
      end
    end
  end

  // Calendar counters, presets and alarm registers.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      date_time_count_r <= DATE_COUNT_RST;
      year_count_r <= YEAR_COUNT_RST;
      date_time_alarm_r <= 32'h0000_0000;
      year_alarm_r <= YEAR_ALARM_RST;
      date_time_preset_r <= 32'h0000_0000;
      year_preset_r <= 14'h0000;
      preset_pend_r <= 1'b0;
      cal_upd_r <= 1'b0;
    end else begin
      cal_upd_r <= hz_tick;
      if (wr_pend_r && wr_addr_r == OFS_DATE_ALARM) date_time_alarm_r <= {3'h0, hwdata_i[28:0]};
      if (wr_pend_r && wr_addr_r == OFS_YEAR_ALARM) year_alarm_r <= hwdata_i[13:0];
      if (wr_pend_r && wr_addr_r == OFS_YEAR_PRESET) year_preset_r <= hwdata_i[13:0];
      if (wr_pend_r && wr_addr_r == OFS_DATE_PRESET) begin
        date_time_preset_r <= {3'h0, hwdata_i[28:0]};
        preset_pend_r <= 1'b1;
      end else if (hz_tick) begin
        preset_pend_r <= 1'b0;
      end
      if (hz_tick) begin
        if (preset_pend_r) begin
          date_time_count_r <= date_time_preset_r;
          year_count_r <= year_preset_r;
        end else begin
          date_time_count_r <= date_nxt;
          year_count_r <= year_nxt;
        end
      end
    end
  end

  // Alarm comparison; zero weekday, day, month and year fields are wildcards.
  assign alarm_match =
    (date_time_count_r[16:0] == date_time_alarm_r[16:0]) &&
    (date_time_alarm_r[DAYW_LSB +: 3] == 3'h0 ||
     date_time_alarm_r[DAYW_LSB +: 3] == date_time_count_r[DAYW_LSB +: 3]) &&
    (date_time_alarm_r[DAYM_LSB +: 5] == 5'h00 ||
     date_time_alarm_r[DAYM_LSB +: 5] == date_time_count_r[DAYM_LSB +: 5]) &&
    (date_time_alarm_r[MONTH_LSB +: 4] == 4'h0 ||
     date_time_alarm_r[MONTH_LSB +: 4] == date_time_count_r[MONTH_LSB +: 4]) &&
    (year_alarm_r == 14'h0000 || year_alarm_r == year_count_r);

  // Mask register and sticky raw status; a new event beats a clear.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_mask_reg_r <= 2'b00;
      raw_irq_status_r <= 2'b00;
    end else begin
      if (wr_pend_r && wr_addr_r == OFS_IRQ_MASK) irq_mask_reg_r <= hwdata_i[1:0];
      if (cal_upd_r && alarm_match) begin
        raw_irq_status_r[IRQ_ALARM_BIT] <= 1'b1;
      end else if (wr_clr && hwdata_i[IRQ_ALARM_BIT]) begin
        raw_irq_status_r[IRQ_ALARM_BIT] <= 1'b0;
      end
      if (zero_evt) begin
        raw_irq_status_r[IRQ_COUNTDOWN_BIT] <= 1'b1;
      end else if (wr_clr && hwdata_i[IRQ_COUNTDOWN_BIT]) begin
        raw_irq_status_r[IRQ_COUNTDOWN_BIT] <= 1'b0;
      end
    end
  end

  assign combined_irq_o = |(raw_irq_status_r & irq_mask_reg_r);

  sequence s_run_tick;
    ls_tick && timer_run_bit && countdown_value_r != 32'h0000_0000 && !wr_ctrl
      && !wr_rl1 && !wr_rl2;
  endsequence
  sequence s_oneshot_zero;
    zero_evt && oneshot_select && !wr_ctrl;
  endsequence

  property p_decrement;
    @(posedge clk_i) disable iff (!rst_b_i)
    s_run_tick |=> countdown_value_r == $past(countdown_value_r) - 32'h0000_0001;
  endproperty
  a_decrement: assert property (p_decrement) else $error("count did not decrement");

  property p_oneshot_halt;
    @(posedge clk_i) disable iff (!rst_b_i)
    s_oneshot_zero |=> !timer_run_bit && countdown_value_r == 32'h0000_0000
      && raw_irq_status_r[IRQ_COUNTDOWN_BIT];
  endproperty
  a_oneshot_halt: assert property (p_oneshot_halt) else $error("one-shot did not halt");

  property p_periodic_reload;
    @(posedge clk_i) disable iff (!rst_b_i)
    zero_evt && !oneshot_select && !wr_ctrl |=> countdown_value_r ==
      ($past(pat_bit) ? second_reload_value_r : first_reload_value_r);
  endproperty
  a_periodic_reload: assert property (p_periodic_reload) else $error("bad reload");

  property p_reload_locked;
    @(posedge clk_i) disable iff (!rst_b_i)
    (wr_rl1 || wr_rl2) && timer_run_bit |=> $stable(first_reload_value_r)
      && $stable(second_reload_value_r);
  endproperty
  a_reload_locked: assert property (p_reload_locked) else $error("reload changed");

  property p_selfstart;
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_rl1 && !timer_run_bit && oneshot_select && ctrl_r[CTRL_SELFSTART_BIT] && !wr_ctrl
      |=> timer_run_bit && countdown_value_r == $past(hwdata_i);
  endproperty
  a_selfstart: assert property (p_selfstart) else $error("self-start failed");

  property p_alarm_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
    raw_irq_status_r[IRQ_ALARM_BIT] && !(wr_clr && hwdata_i[IRQ_ALARM_BIT])
      |=> raw_irq_status_r[IRQ_ALARM_BIT];
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped");

  property p_alarm_raise;
    @(posedge clk_i) disable iff (!rst_b_i)
    hz_tick ##1 alarm_match |=> raw_irq_status_r[IRQ_ALARM_BIT];
  endproperty
  a_alarm_raise: assert property (p_alarm_raise) else $error("alarm missed");

  property p_combined;
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(raw_irq_status_r[IRQ_COUNTDOWN_BIT]) && irq_mask_reg_r[IRQ_COUNTDOWN_BIT]
      |-> combined_irq_o;
  endproperty
  a_combined: assert property (p_combined) else $error("combined irq low");

  property p_preset;
    @(posedge clk_i) disable iff (!rst_b_i)
    hz_tick && preset_pend_r |=> date_time_count_r == $past(date_time_preset_r);
  endproperty
  a_preset: assert property (p_preset) else $error("preset not loaded");

endmodule : realtime_timer_calendar

/* realtime_timer_and_calendar_tb_top.sv */
// Purpose: Self-checking bench for the countdown timer and calendar block.
// Assumes: Zero-wait AHB-Lite slave; the bench drives the low-speed and 1 Hz pins.
// Notes: Low-speed and 1 Hz edges are slow pulses, resynchronised inside the block.
`timescale 1ns/1ps
module realtime_timer_and_calendar_tb_top
  import realtime_pkg::*;
;
  localparam logic [31:0] AL_M = 32'h1 << IRQ_ALARM_BIT;
  localparam logic [31:0] CD_M = 32'h1 << IRQ_COUNTDOWN_BIT;
  localparam logic [31:0] RUN_M = 32'h1 << CTRL_RUN_BIT;
  localparam logic [31:0] OS_M = 32'h1 << CTRL_ONESHOT_BIT;
  localparam logic [31:0] SS_M = 32'h1 << CTRL_SELFSTART_BIT;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'b00;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'b010;
  logic [31:0] hwdata_i = 32'h0;
  logic hready_i;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  logic lsclk_i = 1'b0;
  logic one_hz_tick_i = 1'b0;
  logic combined_irq_o;
  int bad_count = 0;
  int check_count = 0;

  // The single slave's ready is the bus ready.
  assign hready_i = hreadyout_o;

  always #50 clk_i = ~clk_i;

  realtime_timer_calendar u_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .lsclk_i(lsclk_i), .one_hz_tick_i(one_hz_tick_i),
    .combined_irq_o(combined_irq_o)
  );

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Bounded wait for hready sampled high at a rising edge.
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 16);
    if (hreadyout_o !== 1'b1) begin
      bad_count++;
      $display("[FAIL] hready expected 1 seen %b", hreadyout_o);
      give_verdict();
    end
  endtask : wait_rdy

  // One idle cycle follows each write so a read right after sees the new value.
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    haddr_i <= {24'h0, a};
    htrans_i <= 2'b10;
    hwrite_i <= 1'b1;
    hsel_i <= 1'b1;
    wait_rdy();
    htrans_i <= 2'b00;
    hwdata_i <= d;
    wait_rdy();
    hsel_i <= 1'b0;
    hwrite_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus_wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    haddr_i <= {24'h0, a};
    htrans_i <= 2'b10;
    hwrite_i <= 1'b0;
    hsel_i <= 1'b1;
    wait_rdy();
    htrans_i <= 2'b00;
    wait_rdy();
    chk(nm, e, hrdata_o);
    chk("hresp", 32'h0, {31'h0, hresp_o});
    hsel_i <= 1'b0;
    @(posedge clk_i);
  endtask : rd_chk

  task automatic ls_tick();
    lsclk_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    lsclk_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : ls_tick

  task automatic hz_tick();
    one_hz_tick_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    one_hz_tick_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : hz_tick

  // Control writes keep the required spacing of about 150 us.
  task automatic ctrl_wr(input logic [31:0] d);
    bus_wr(OFS_TIMER_CTRL, d);
    repeat (1500) @(posedge clk_i);
  endtask : ctrl_wr

  function automatic logic [31:0] mk(int s, int m, int h, int w, int dm, int mo);
    return (32'(s) << SEC_LSB) | (32'(m) << MIN_LSB) | (32'(h) << HOUR_LSB) |
      (32'(w) << DAYW_LSB) | (32'(dm) << DAYM_LSB) | (32'(mo) << MONTH_LSB);
  endfunction : mk

  task automatic test_reset();
    rd_chk(OFS_DATE_COUNT, DATE_COUNT_RST, "date_reset");
    rd_chk(OFS_YEAR_COUNT, 32'(YEAR_COUNT_RST), "year_reset");
    rd_chk(OFS_COUNTDOWN, COUNTDOWN_RST, "count_reset");
    rd_chk(OFS_RAW_STATUS, 32'h0, "raw_reset");
    rd_chk(8'h18, 32'h0, "unmapped");
    $display("test_reset done");
  endtask : test_reset

  task automatic test_oneshot();
    ctrl_wr(OS_M | SS_M);
    bus_wr(OFS_FIRST_RELOAD, 32'h2);
    rd_chk(OFS_TIMER_CTRL, OS_M | SS_M | RUN_M, "selfstart_run");
    rd_chk(OFS_COUNTDOWN, 32'h2, "oneshot_load");
    ls_tick();
    ls_tick();
    rd_chk(OFS_RAW_STATUS, 32'h0, "raw_before_zero");
    ls_tick();
    rd_chk(OFS_RAW_STATUS, CD_M, "raw_at_zero");
    rd_chk(OFS_MASKED_STATUS, 32'h0, "masked_off");
    chk("irq_masked", 32'h0, {31'h0, combined_irq_o});
    rd_chk(OFS_TIMER_CTRL, OS_M | SS_M, "oneshot_halt");
    bus_wr(OFS_IRQ_MASK, CD_M);
    rd_chk(OFS_MASKED_STATUS, CD_M, "masked_on");
    chk("irq_on", 32'h1, {31'h0, combined_irq_o});
    bus_wr(OFS_IRQ_CLEAR, CD_M);
    ls_tick();
    rd_chk(OFS_RAW_STATUS, 32'h0, "single_irq");
    rd_chk(OFS_COUNTDOWN, 32'h0, "stays_zero");
    ctrl_wr(OS_M | SS_M | RUN_M);
    rd_chk(OFS_COUNTDOWN, 32'h2, "restart_run");
    $display("test_oneshot done");
  endtask : test_oneshot

  task automatic test_periodic();
    ctrl_wr(32'h0);
    bus_wr(OFS_FIRST_RELOAD, 32'h1);
    bus_wr(OFS_SECOND_RELOAD, 32'h3);
    bus_wr(OFS_PATTERN0, 32'h2);
    rd_chk(OFS_PATTERN0, 32'h2, "pattern_back");
    ctrl_wr(RUN_M | (32'h2 << CTRL_PATLEN_LSB));
    rd_chk(OFS_TIMER_CTRL, RUN_M | (32'h2 << CTRL_PATLEN_LSB), "ctrl_back");
    bus_wr(OFS_FIRST_RELOAD, 32'h9);
    rd_chk(OFS_FIRST_RELOAD, 32'h1, "reload_locked");
    ls_tick();
    ls_tick();
    rd_chk(OFS_COUNTDOWN, 32'h1, "reload_first");
    rd_chk(OFS_RAW_STATUS, CD_M, "periodic_irq");
    bus_wr(OFS_IRQ_CLEAR, CD_M);
    ls_tick();
    ls_tick();
    rd_chk(OFS_COUNTDOWN, 32'h3, "reload_second");
    rd_chk(OFS_RAW_STATUS, CD_M, "periodic_irq2");
    bus_wr(OFS_IRQ_CLEAR, CD_M);
    ctrl_wr(32'h0);
    rd_chk(OFS_RAW_STATUS, 32'h0, "cleared");
    $display("test_periodic done");
  endtask : test_periodic

  task automatic test_calendar();
    logic [31:0] pre [4];
    logic [31:0] py [4];
    logic [31:0] ed [4];
    logic [31:0] ey [4];
    logic [31:0] al [4];
    pre = '{mk(59, 59, 23, 7, 28, 2), mk(59, 59, 23, 3, 28, 2),
      mk(59, 59, 23, 5, 31, 12), mk(59, 59, 23, 1, 31, 12)};
    py = '{32'd2023, 32'd2024, 32'd2024, 32'd4096};
    ed = '{mk(0, 0, 0, 1, 1, 3), mk(0, 0, 0, 4, 29, 2), mk(0, 0, 0, 6, 1, 1),
      mk(0, 0, 0, 2, 1, 1)};
    ey = '{32'd2023, 32'd2024, 32'd2025, 32'd0};
    al = '{AL_M, 32'h0, 32'h0, 32'h0};
    bus_wr(OFS_IRQ_MASK, AL_M | CD_M);
    bus_wr(OFS_DATE_ALARM, mk(0, 0, 0, 0, 1, 3));
    bus_wr(OFS_YEAR_ALARM, 32'd2023);
    for (int i = 0; i < 4; i++) begin
      bus_wr(OFS_YEAR_PRESET, py[i]);
      bus_wr(OFS_DATE_PRESET, pre[i]);
      hz_tick();
      rd_chk(OFS_DATE_COUNT, pre[i], "preset_date");
      rd_chk(OFS_YEAR_COUNT, py[i], "preset_year");
      hz_tick();
      rd_chk(OFS_DATE_COUNT, ed[i], "next_date");
      rd_chk(OFS_YEAR_COUNT, ey[i], "next_year");
      rd_chk(OFS_RAW_STATUS, al[i], "alarm_raw");
      chk("alarm_irq", al[i] >> IRQ_ALARM_BIT, {31'h0, combined_irq_o});
      hz_tick();
      rd_chk(OFS_RAW_STATUS, al[i], "alarm_sticky");
      bus_wr(OFS_IRQ_CLEAR, AL_M);
      rd_chk(OFS_RAW_STATUS, 32'h0, "alarm_clear");
    end
    $display("test_calendar done");
  endtask : test_calendar

  initial begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    test_reset();
    test_oneshot();
    test_periodic();
    test_calendar();
    give_verdict();
  end
endmodule : realtime_timer_and_calendar_tb_top
